// >>> serial_baud_regs.vh
`ifndef SERIAL_BAUD_REGS_VH
`define SERIAL_BAUD_REGS_VH

// =====================================================================
// Register map: channel c at byte 16*c, four words per channel.
`define REG_CTRL 2'h0
`define REG_DIV 2'h1
`define REG_FMT 2'h2
`define REG_DATA 2'h3
`define CHAN_LAST 2'h2
`define ADDR_HALT 6'h30

// =====================================================================
// Reset values.
`define CTRL_RST 8'h00
`define DIV_RST 8'h00
`define FMT_RST 8'hf2
`define FMT_FIXED_ONES 8'hf2
`define HALT_RST 16'h3fff

// =====================================================================
// Field positions.
`define CTRL_PRESC_HI 1
`define CTRL_EXT_BIT 2
`define CTRL_CHAR7_BIT 6
`define CTRL_SYNC_BIT 7
`define CTRL_BUSY_BIT 8
`define CTRL_FULL_BIT 9
`define FMT_ORDER_BIT 3
`define FMT_INVERT_BIT 2
`define FMT_CARD_BIT 0
`define HALT_CH0_BIT 5

// =====================================================================
// Timing counts.
`define PRESC_LAST_N0 6'h00
`define PRESC_LAST_N1 6'h03
`define PRESC_LAST_N2 6'h0f
`define PRESC_LAST_N3 6'h3f
`define MID_SAMPLE_TICK 4'h7
`define ASYNC_BITS_8 4'ha
`define ASYNC_BITS_7 4'h9
`define SYNC_BITS 4'h8

// =====================================================================
// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> serial_baud_bitorder_stop.v
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_baud_regs.vh"

module serial_baud_bitorder_stop (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire ce, // clock enable, freezes all state when low
	input wire standby, // standby mode request level
	input wire [5:0] awaddr, // write address
	input wire awvalid, // write address valid
	output wire awready, // write address ready
	input wire [31:0] wdata, // write data
	input wire [3:0] wstrb, // write byte strobes
	input wire wvalid, // write data valid
	output wire wready, // write data ready
	output wire [1:0] bresp, // write response
	output wire bvalid, // write response valid
	input wire bready, // write response ready
	input wire [5:0] araddr, // read address
	input wire arvalid, // read address valid
	output wire arready, // read address ready
	output wire [31:0] rdata, // read data
	output wire [1:0] rresp, // read response
	output wire rvalid, // read data valid
	input wire rready, // read data ready
	input wire [2:0] rxd, // serial receive pins
	input wire [2:0] sck_in, // serial clock pin inputs
	output wire [2:0] txd, // serial transmit pins
	output wire [2:0] sck_out, // serial clock pin outputs
	output wire [2:0] sck_oe // serial clock pin output enables
);

	// =================================================================
	// Helper functions.
	function [5:0] presc_last;
		input [1:0] n;
		begin
			case (n)
				2'h0: presc_last = `PRESC_LAST_N0;
				2'h1: presc_last = `PRESC_LAST_N1;
				2'h2: presc_last = `PRESC_LAST_N2;
				default: presc_last = `PRESC_LAST_N3;
			endcase
		end
	endfunction

	function [7:0] rev8;
		input [7:0] d;
		integer k;
		begin
			for (k = 0; k < 8; k = k + 1)
				rev8[k] = d[7 - k];
		end
	endfunction

	// Bits arrive shifted in at the top, first bit ends at bit 0 (at bit 1 for 7-bit characters).
	function [7:0] rx_asm;
		input [7:0] sr;
		input char7;
		input msb;
		begin
			if (char7)
				rx_asm = {1'b0, sr[7:1]};
			else if (msb)
				rx_asm = rev8(sr);
			else
				rx_asm = sr;
		end
	endfunction

	function addr_ok;
		input [5:0] a;
		begin
			addr_ok = (a[5:4] <= `CHAN_LAST) || (a == `ADDR_HALT);
		end
	endfunction

	// =================================================================
	// Register file and AXI4-Lite slave.
	reg [7:0] ctrl_reg [0:2];
	reg [7:0] div_reg [0:2];
	reg [7:0] fmt_reg [0:2];
	reg [7:0] txval_reg [0:2];
	reg [15:0] halt_reg;
	reg [2:0] div_wr_reg;
	reg [2:0] tx_go_reg;
	reg [2:0] rd_clr_reg;
	reg awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	reg [1:0] bresp_reg, rresp_reg;
	reg [31:0] rdata_reg;
	reg aw_have, w_have;
	reg [5:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [23:0] rx_dat_all;
	wire [2:0] busy_all;
	wire [2:0] full_all;
	wire [1:0] wch = aw_addr[5:4];
	wire [1:0] rch = araddr[5:4];
	integer c;

	always @(posedge aclk) begin
		if (!aresetn) begin
			for (c = 0; c < 3; c = c + 1) begin
				ctrl_reg[c] <= `CTRL_RST;
				div_reg[c] <= `DIV_RST;
				fmt_reg[c] <= `FMT_RST;
				txval_reg[c] <= 8'h00;
			end
			halt_reg <= `HALT_RST;
			div_wr_reg <= 3'h0;
			tx_go_reg <= 3'h0;
			rd_clr_reg <= 3'h0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= `RESP_OKAY;
			rdata_reg <= 32'h00000000;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (ce) begin
			div_wr_reg <= 3'h0;
			tx_go_reg <= 3'h0;
			rd_clr_reg <= 3'h0;
			if (awvalid && awready_reg) begin
				aw_addr <= awaddr;
				aw_have <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (wvalid && wready_reg) begin
				w_data <= wdata;
				w_strb <= wstrb;
				w_have <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (aw_have && w_have && !bvalid_reg) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= addr_ok(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
				if (aw_addr == `ADDR_HALT) begin
					if (w_strb[0])
						halt_reg[7:0] <= w_data[7:0];
					if (w_strb[1])
						halt_reg[15:8] <= w_data[15:8];
				end else if (wch <= `CHAN_LAST && w_strb[0]) begin
					case (aw_addr[3:2])
						`REG_CTRL: ctrl_reg[wch] <= w_data[7:0];
						`REG_DIV: begin
							div_reg[wch] <= w_data[7:0];
							div_wr_reg[wch] <= 1'b1;
						end
						`REG_FMT: fmt_reg[wch] <= w_data[7:0] | `FMT_FIXED_ONES;
						default: begin
							txval_reg[wch] <= w_data[7:0];
							tx_go_reg[wch] <= 1'b1;
						end
					endcase
				end
			end
			if (bvalid_reg && bready) begin
				bvalid_reg <= 1'b0;
				aw_have <= 1'b0;
				w_have <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
			if (arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rresp_reg <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
				rdata_reg <= 32'h00000000;
				if (araddr == `ADDR_HALT)
					rdata_reg <= {16'h0000, halt_reg};
				else if (rch <= `CHAN_LAST) begin
					case (araddr[3:2])
						`REG_CTRL: rdata_reg <= {22'h000000, full_all[rch], busy_all[rch], ctrl_reg[rch]};
						`REG_DIV: rdata_reg <= {24'h000000, div_reg[rch]};
						`REG_FMT: rdata_reg <= {24'h000000, fmt_reg[rch]};
						default: begin
							rdata_reg <= {24'h000000, rx_dat_all[8 * rch +: 8]};
							rd_clr_reg[rch] <= 1'b1;
						end
					endcase
				end
			end
			if (rvalid_reg && rready) begin
				rvalid_reg <= 1'b0;
				arready_reg <= 1'b1;
			end
			// The format register is held at its reset value while standing by or halted.
			for (c = 0; c < 3; c = c + 1)
				if (standby || halt_reg[`HALT_CH0_BIT + c])
					fmt_reg[c] <= `FMT_RST;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = rdata_reg;

	// =================================================================
	// Serial channels.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : chan
			wire halted = halt_reg[`HALT_CH0_BIT + gi];
			wire [7:0] cfg = ctrl_reg[gi];
			wire sync_m = cfg[`CTRL_SYNC_BIT];
			wire ext = cfg[`CTRL_EXT_BIT];
			wire char7 = cfg[`CTRL_CHAR7_BIT] & ~sync_m;
			wire msb_first = fmt_reg[gi][`FMT_ORDER_BIT] & ~char7;
			reg [2:0] rx_s, ck_s;
			reg rx_f, ck_f, rx_prev, ck_prev;
			reg [5:0] pre_cnt;
			reg [7:0] brg_cnt;
			reg half;
			reg txd_r, sck_r, sck_oe_r, busy_r, rbusy_r, full_r;
			reg [3:0] ttick, rtick, tbit, rbit;
			reg [9:0] tsr;
			reg [7:0] rsr, rdat;
			wire [7:0] tx_ord = msb_first ? rev8(txval_reg[gi]) : txval_reg[gi];
			wire ptick = (pre_cnt == presc_last(cfg[`CTRL_PRESC_HI:0]));
			wire rpulse = ptick && (brg_cnt == 8'h00);
			wire int_tick = rpulse & half;
			wire ck_rise = ck_f & ~ck_prev;
			wire ck_fall = ~ck_f & ck_prev;
			wire tick16 = ext ? ck_rise : int_tick;
			wire shift_ev = ext ? ck_fall : (int_tick & sck_r);
			wire samp_ev = ext ? ck_rise : (int_tick & ~sck_r);

			always @(posedge aclk) begin
				if (!aresetn || (ce && halted)) begin
					rx_s <= 3'h7;
					ck_s <= 3'h7;
					rx_f <= 1'b1;
					ck_f <= 1'b1;
					rx_prev <= 1'b1;
					ck_prev <= 1'b1;
					pre_cnt <= 6'h00;
					brg_cnt <= 8'h00;
					half <= 1'b0;
					txd_r <= 1'b1;
					sck_r <= 1'b1;
					sck_oe_r <= 1'b0;
					busy_r <= 1'b0;
					rbusy_r <= 1'b0;
					full_r <= 1'b0;
					ttick <= 4'h0;
					rtick <= 4'h0;
					tbit <= 4'h0;
					rbit <= 4'h0;
					tsr <= 10'h3ff;
					rsr <= 8'h00;
					rdat <= 8'h00;
				end else if (ce) begin
					rx_s <= {rx_s[1:0], rxd[gi]};
					ck_s <= {ck_s[1:0], sck_in[gi]};
					if (rx_s[1] == rx_s[2])
						rx_f <= rx_s[1];
					if (ck_s[1] == ck_s[2])
						ck_f <= ck_s[1];
					rx_prev <= rx_f;
					ck_prev <= ck_f;
					sck_oe_r <= sync_m & ~ext;
					if (!sync_m || ext)
						sck_r <= 1'b1;
					// Rate generator: prescaler then divisor down-counter.
					if (div_wr_reg[gi]) begin
						pre_cnt <= 6'h00;
						brg_cnt <= div_reg[gi];
						half <= 1'b0;
					end else if (ptick) begin
						pre_cnt <= 6'h00;
						brg_cnt <= (brg_cnt == 8'h00) ? div_reg[gi] : brg_cnt - 8'h01;
						if (rpulse)
							half <= ~half;
					end else
						pre_cnt <= pre_cnt + 6'h01;
					if (rd_clr_reg[gi])
						full_r <= 1'b0;
					// A new character is only taken once the previous one is fully out.
					if (tx_go_reg[gi] && !busy_r) begin
						busy_r <= 1'b1;
						ttick <= 4'h0;
						if (sync_m) begin
							tsr <= {2'h3, tx_ord};
							tbit <= `SYNC_BITS;
						end else if (char7) begin
							tsr <= {3'h7, tx_ord[6:0]};
							tsr[0] <= 1'b0;
							tsr[7:1] <= tx_ord[6:0];
							tbit <= `ASYNC_BITS_7;
						end else begin
							tsr <= {1'b1, tx_ord, 1'b0};
							tbit <= `ASYNC_BITS_8;
						end
					end else if (busy_r && sync_m) begin
						if (shift_ev) begin
							txd_r <= tsr[0];
							tsr <= {1'b1, tsr[9:1]};
							if (!ext)
								sck_r <= 1'b0;
						end
						if (samp_ev) begin
							rsr <= {rx_f, rsr[7:1]};
							tbit <= tbit - 4'h1;
							if (!ext)
								sck_r <= 1'b1;
							if (tbit == 4'h1) begin
								busy_r <= 1'b0;
								txd_r <= 1'b1;
								rdat <= rx_asm({rx_f, rsr[7:1]}, 1'b0, msb_first);
								full_r <= 1'b1;
							end
						end
					end else if (busy_r && tick16) begin
						ttick <= ttick + 4'h1;
						if (ttick == 4'h0) begin
							if (tbit == 4'h0)
								busy_r <= 1'b0;
							else begin
								txd_r <= tsr[0];
								tsr <= {1'b1, tsr[9:1]};
								tbit <= tbit - 4'h1;
							end
						end
					end
					// Asynchronous receiver.
					if (!sync_m) begin
						if (!rbusy_r) begin
							if (rx_prev && !rx_f) begin
								rbusy_r <= 1'b1;
								rtick <= 4'h0;
								rbit <= 4'h0;
							end
						end else if (tick16) begin
							rtick <= rtick + 4'h1;
							if (rtick == `MID_SAMPLE_TICK) begin
								rbit <= rbit + 4'h1;
								if (rbit == 4'h0) begin
									if (rx_f)
										rbusy_r <= 1'b0;
								end else if (rbit == (char7 ? `ASYNC_BITS_7 : `ASYNC_BITS_8) - 4'h1) begin
									rbusy_r <= 1'b0;
									rdat <= rx_asm(rsr, char7, msb_first);
									full_r <= 1'b1;
								end else
									rsr <= {rx_f, rsr[7:1]};
							end
						end
					end else
						rbusy_r <= 1'b0;
				end
			end

			assign txd[gi] = txd_r;
			assign sck_out[gi] = sck_r;
			assign sck_oe[gi] = sck_oe_r;
			assign busy_all[gi] = busy_r;
			assign full_all[gi] = full_r;
			assign rx_dat_all[8 * gi +: 8] = rdat;
		end
	endgenerate

endmodule // serial_baud_bitorder_stop

`default_nettype wire

// >>> serial_baud_bitorder_stop_end.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> serial_baud_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus and pin relations seen at the block boundary.
module serial_baud_checker (
	input wire aclk, // clock
	input wire aresetn, // reset, active low
	input wire ce, // clock enable
	input wire [5:0] araddr, // read address
	input wire arvalid, // read address valid
	input wire arready, // read address ready
	input wire [31:0] rdata, // read data
	input wire [1:0] rresp, // read response
	input wire rvalid, // read valid
	input wire rready, // read ready
	input wire awready, // write address ready
	input wire wready, // write data ready
	input wire [1:0] bresp, // write response
	input wire bvalid, // write response valid
	input wire bready, // write response ready
	input wire [2:0] txd // transmit pins
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> txd == 3'h7 && !bvalid && !rvalid)
		else $error("outputs not idle after reset");
	read_answer_a: assert property (ce && arvalid && arready |=> rvalid)
		else $error("read not answered");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer changed");
	read_end_a: assert property (ce && rvalid && rready |=> !rvalid)
		else $error("read answer kept");
	read_busy_a: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
	write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer changed");
	write_busy_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while busy");
	bad_addr_a: assert property (ce && arvalid && arready && araddr >= 6'h34 |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read not refused");
	fmt_ones_a: assert property (ce && arvalid && arready && araddr[3:0] == 4'h8 && araddr < 6'h30 |=> (rdata & 32'hf2) == 32'hf2)
		else $error("fixed format bits not one");
	halt_width_a: assert property (ce && arvalid && arready && araddr == 6'h30 |=> rdata[31:16] == 16'h0)
		else $error("halt register too wide");
endmodule // serial_baud_checker
bind serial_baud_bitorder_stop serial_baud_checker serial_baud_checker_inst (.aclk(aclk), .aresetn(aresetn),
	.ce(ce), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .awready(awready), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .txd(txd));
`default_nettype wire

// >>> remote_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Remote peer: echoes each transmit line back and supplies no clock of its own.
module remote_serial_peer (
	input wire logic [2:0] txd, // device transmit
	input wire logic [2:0] sck_out, // device clock out
	input wire logic [2:0] sck_oe, // device clock enable
	output logic [2:0] rxd, // device receive
	output logic [2:0] sck_in // clock pin level
);
	assign rxd = txd;
	// The clock pin is pulled high when the device does not drive it, so no external rate is exceeded.
	assign sck_in = (sck_oe & sck_out) | ~sck_oe;
endmodule // remote_serial_peer
`default_nettype wire

// >>> serial_baud_bitorder_stop_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register access and serial frame tests.
module serial_baud_bitorder_stop_tb_top;
	logic aclk, aresetn, ce, standby, awvalid, wvalid, bready, arvalid, rready;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rd_data;
	logic [3:0] wstrb;
	logic [1:0] wr_resp, rd_resp;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] rxd, sck_in, txd, sck_out, sck_oe;
	int miscompares = 0;
	int samples_checked = 0;
	serial_baud_bitorder_stop serial_baud_bitorder_stop_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.standby(standby), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rxd(rxd), .sck_in(sck_in), .txd(txd), .sck_out(sck_out),
		.sck_oe(sck_oe));
	remote_serial_peer remote_serial_peer_inst (.txd(txd), .sck_out(sck_out), .sck_oe(sck_oe), .rxd(rxd),
		.sck_in(sck_in));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && t < 1000);
		if (!bvalid) miscompares++;
		wr_resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [5:0] a);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && t < 1000);
		if (!rvalid) miscompares++;
		rd_data = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
		axi_read(a);
		check(rd_data, exp);
	endtask
	// Sends one byte on channel 0 and samples each bit in its middle; the peer echoes it back.
	task automatic frame_check(input logic [7:0] ctl, input logic [7:0] div, input logic [7:0] fmt,
		input logic [7:0] d, input int per);
		int i, t, n;
		logic msb;
		msb = fmt[3] && !ctl[6];
		n = ctl[6] ? 7 : 8;
		t = 0;
		axi_write(6'h00, {24'h0, ctl});
		axi_write(6'h04, {24'h0, div});
		axi_write(6'h08, {24'h0, fmt});
		axi_write(6'h0c, {24'h0, d});
		while (txd[0] && t < 4000) begin
			@(posedge aclk);
			t++;
		end
		if (txd[0]) miscompares++;
		repeat (per / 2) @(posedge aclk);
		check(txd[0], 1'b0);
		for (i = 0; i < n; i++) begin
			repeat (per) @(posedge aclk);
			check(txd[0], msb ? d[7 - i] : d[i]);
		end
		repeat (per) @(posedge aclk);
		check(txd[0], 1'b1);
		repeat (per) @(posedge aclk);
		rd_check(6'h0c, ctl[6] ? {25'h0, d[6:0]} : {24'h0, d});
	endtask
	initial begin
		repeat (30000) @(posedge aclk);
		miscompares++;
		complete_run;
	end
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		standby = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 6'h00;
		araddr = 6'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd_check(6'h08, 32'hf2);
		rd_check(6'h30, 32'h3fff);
		axi_read(6'h34);
		check(rd_resp, 2'h2);
		axi_write(6'h3c, 32'h1);
		check(wr_resp, 2'h2);
		axi_write(6'h30, 32'hffff);
		rd_check(6'h30, 32'hffff);
		axi_write(6'h30, 32'h0);
		rd_check(6'h30, 32'h0);
		axi_write(6'h08, 32'h0d);
		rd_check(6'h08, 32'hff);
		axi_write(6'h08, 32'h00);
		rd_check(6'h08, 32'hf2);
		axi_write(6'h04, 32'hff);
		rd_check(6'h04, 32'hff);
		$display("register test done");
		axi_write(6'h08, 32'h08);
		standby <= 1'b1;
		@(posedge aclk);
		standby <= 1'b0;
		rd_check(6'h08, 32'hf2);
		rd_check(6'h30, 32'h0);
		axi_write(6'h08, 32'h08);
		axi_write(6'h30, 32'h20);
		rd_check(6'h08, 32'hf2);
		axi_write(6'h30, 32'h40);
		axi_write(6'h1c, 32'h00);
		repeat (100) @(posedge aclk);
		check(txd, 3'h7);
		$display("halt test done");
		frame_check(8'h00, 8'h00, 8'h00, 8'ha5, 32);
		frame_check(8'h01, 8'h01, 8'h08, 8'h3c, 256);
		frame_check(8'h02, 8'h00, 8'h00, 8'hc3, 512);
		frame_check(8'h40, 8'h00, 8'h08, 8'h35, 32);
		$display("frame test done");
		// Synchronous loop-back at divisor 3: one bit per 16 cycles, shifted on the fall, sampled on the rise.
		axi_write(6'h04, 32'h03);
		axi_write(6'h00, 32'h80);
		axi_write(6'h0c, 32'ha6);
		repeat (200) @(posedge aclk);
		check(sck_oe, 3'h1);
		check(sck_out, 3'h7);
		rd_check(6'h00, 32'h280);
		rd_check(6'h0c, 32'ha6);
		rd_check(6'h00, 32'h80);
		$display("sync test done");
		// With an external clock and no edges at the pin, the internal divisor must not move the transmitter.
		axi_write(6'h00, 32'h04);
		axi_write(6'h0c, 32'h55);
		repeat (100) @(posedge aclk);
		check(txd, 3'h7);
		rd_check(6'h00, 32'h104);
		axi_write(6'h30, 32'h60);
		rd_check(6'h00, 32'h04);
		$display("external clock test done");
		complete_run;
	end
endmodule // serial_baud_bitorder_stop_tb_top
`default_nettype wire
